// >>> logic/cspm_pkg.sv
// package: constants and bundles for the strap sampler and pin multiplexer
`default_nettype none
package cspm_pkg;
   // configuration register numbers behind the index port
   localparam logic [7:0] IDX_CONFIG_ONE = 8'h21;
   localparam logic [7:0] IDX_CONFIG_TWO = 8'h22;
   localparam logic [7:0] IDX_RELOC_LO = 8'h26;
   localparam logic [7:0] IDX_RELOC_HI = 8'h27;
   // field positions
   localparam int XBUF_EN_BIT = 4;
   localparam int PORT2_SEL_BIT = 3;
   localparam int CS_ROUTE_BIT = 1;
   localparam int BASE_HI_BIT = 1;
   localparam int BASE_LO_BIT = 0;
   // values after reset, before the straps land
   localparam logic [7:0] CONFIG_ONE_RESET = 8'h00;
   localparam logic [7:0] CONFIG_TWO_RESET = 8'h00;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   // port addresses
   localparam logic [15:0] PNP_INDEX_ADDR = 16'h0279;
   localparam logic [15:0] PNP_DATA_WR_ADDR = 16'h0a79;
   localparam logic [15:0] MB_BASE_LO0 = 16'h015c;
   localparam logic [15:0] MB_BASE_LO1 = 16'h002e;
   localparam logic [15:0] BASE_RESET = 16'h0000;
   // pad groups: all outputs off, all inputs idle high
   localparam logic [9:0] XB_PADS_OFF = 10'h3ff;
   localparam logic [5:0] P3_PADS_OFF = 6'h3f;
   // port-2 pad drive pattern: request-to-send (3) and serial-out (5) driven
   localparam logic [5:0] P3_UART_OE_N = 6'h17;
   localparam int XB_STRAP_PAD = 8;

   typedef enum logic [1:0] {
      WAIT_FOR_KEY = 2'b01,
      CONFIG_STATE = 2'b10
   } cspm_state_type;

   typedef struct packed {
      logic base_sel_strap_lo;
      logic base_sel_strap_hi;
      logic config_strap_lo;
      logic config_strap_hi;
   } cspm_strap_type;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } cspm_host_req_type;

   typedef struct packed {
      logic xbuf_chip_select;
      logic xbuf_read_cmd;
      logic [7:0] xbuf_data_lines;
      logic ring_in;
      logic ident_input_3;
      logic [3:0] gpio2_in;
   } cspm_xb_in_type;

   typedef struct packed {
      logic port2_clear_to_send;
      logic port2_carrier_detect;
      logic port2_set_ready;
      logic port2_serial_in;
      logic [5:0] gpio3_in;
   } cspm_p3_in_type;
endpackage
`default_nettype wire

// >>> logic/cspm_mux.sv
// strap sampler, index/data port decoder and shared-pin multiplexer
`default_nettype none
module cspm_mux (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire cspm_pkg::cspm_strap_type strap_pins,
   input wire logic pnp_key_seen,
   input wire cspm_pkg::cspm_host_req_type host_req,
   output logic [7:0] host_rdata,
   output logic host_ack,
   output cspm_pkg::cspm_state_type config_state,
   output logic [7:0] chip_config_one,
   output logic [7:0] chip_config_two,
   output logic [15:0] port_base,
   output logic [4:0] strap_values,
   input wire logic [9:0] xb_pad_in,
   output logic [9:0] xb_pad_out,
   output logic [9:0] xb_pad_oe_n,
   input wire logic [5:0] p3_pad_in,
   output logic [5:0] p3_pad_out,
   output logic [5:0] p3_pad_oe_n,
   input wire logic [7:0] xbuf_data_out,
   input wire logic xbuf_data_drive,
   input wire logic chip_sel_1,
   input wire logic chip_sel_2,
   input wire logic [3:0] gpio2_out,
   input wire logic [3:0] gpio2_drive,
   input wire logic infrared_sel_1,
   input wire logic infrared_sel_2,
   input wire logic port2_request_to_send,
   input wire logic port2_serial_out,
   input wire logic [5:0] gpio3_out,
   input wire logic [5:0] gpio3_drive,
   output cspm_pkg::cspm_xb_in_type xb_in,
   output cspm_pkg::cspm_p3_in_type p3_in
);
   import cspm_pkg::*;

   function automatic logic [15:0] mb_base(input logic lo);
      mb_base = lo ? MB_BASE_LO1 : MB_BASE_LO0;
   endfunction

   logic [3:0] strap_sync1;
   logic [3:0] strap_sync2;
   logic [9:0] xb_sync1;
   logic [9:0] xb_sync2;
   logic [5:0] p3_sync1;
   logic [5:0] p3_sync2;
   logic key_sync1;
   logic key_sync2;
   logic key_prev;
   logic straps_taken;
   logic [7:0] index;
   logic mb_mode;
   logic index_hit;
   logic data_hit;
   logic [7:0] data_rd;
   logic [9:0] next_xb_out;
   logic [9:0] next_xb_oe_n;
   logic [5:0] next_p3_out;
   logic [5:0] next_p3_oe_n;
   logic xbuf_en;
   logic port2_sel;
   logic do_wr;
   logic do_rd;

   ////////////////////////////////////////////////////////////////////
   // input synchronisers: pins come from outside the clock domain

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         strap_sync1 <= 4'h0;
         strap_sync2 <= 4'h0;
         key_sync1 <= 1'b0;
         key_sync2 <= 1'b0;
         key_prev <= 1'b0;
      end else if (clock_enable) begin
         strap_sync1 <= strap_pins;
         strap_sync2 <= strap_sync1;
         key_sync1 <= pnp_key_seen;
         key_sync2 <= key_sync1;
         key_prev <= key_sync2;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         xb_sync1 <= XB_PADS_OFF;
         xb_sync2 <= XB_PADS_OFF;
         p3_sync1 <= P3_PADS_OFF;
         p3_sync2 <= P3_PADS_OFF;
      end else if (clock_enable) begin
         xb_sync1 <= xb_pad_in;
         xb_sync2 <= xb_sync1;
         p3_sync1 <= p3_pad_in;
         p3_sync2 <= p3_sync1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // strap capture: a flop under async reset may not load a pin, so the
   // straps are taken once, on the third enabled edge after release when the syncs hold them

   logic [1:0] settle;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         settle <= 2'd0;
      end else if (clock_enable && settle != 2'd2) begin
         settle <= settle + 2'd1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         straps_taken <= 1'b0;
         strap_values <= 5'h00;
      end else if (clock_enable && !straps_taken && settle == 2'd2) begin
         straps_taken <= 1'b1;
         strap_values <= {xb_sync2[XB_STRAP_PAD], strap_sync2};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wake-up state

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         config_state <= WAIT_FOR_KEY;
      end else if (clock_enable) begin
         case (config_state)
            WAIT_FOR_KEY: begin
               if (!straps_taken && settle == 2'd2 && strap_sync2[2]) begin
                  config_state <= CONFIG_STATE;
               end else if (straps_taken && key_sync2 && !key_prev) begin
                  config_state <= CONFIG_STATE;
               end
            end
            CONFIG_STATE: config_state <= CONFIG_STATE;
            default: config_state <= WAIT_FOR_KEY;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // port decode; host side is on-chip logic, so no synchroniser

   assign mb_mode = chip_config_two[BASE_HI_BIT];

   always_comb begin
      if (mb_mode) begin
         index_hit = host_req.addr == port_base;
         data_hit = host_req.addr == (port_base | 16'h0001);
      end else begin
         // standard index is write-only, data port here is write-only too
         index_hit = host_req.wr && host_req.addr == PNP_INDEX_ADDR;
         data_hit = host_req.wr && host_req.addr == PNP_DATA_WR_ADDR;
      end
   end

   assign do_wr = clock_enable && straps_taken && config_state == CONFIG_STATE
                  && host_req.wr;
   assign do_rd = clock_enable && straps_taken && config_state == CONFIG_STATE
                  && host_req.rd && !host_req.wr;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         index <= INDEX_RESET;
      end else if (do_wr && index_hit) begin
         index <= host_req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         chip_config_one <= CONFIG_ONE_RESET;
      end else if (clock_enable && !straps_taken && settle == 2'd2) begin
         chip_config_one[XBUF_EN_BIT] <= strap_sync2[0];
         chip_config_one[CS_ROUTE_BIT] <= xb_sync2[XB_STRAP_PAD];
      end else if (do_wr && data_hit && index == IDX_CONFIG_ONE) begin
         chip_config_one <= host_req.wdata;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         chip_config_two <= CONFIG_TWO_RESET;
      end else if (clock_enable && !straps_taken && settle == 2'd2) begin
         chip_config_two[BASE_HI_BIT] <= strap_sync2[2];
         chip_config_two[BASE_LO_BIT] <= strap_sync2[3];
      end else if (do_wr && data_hit && index == IDX_CONFIG_TWO) begin
         chip_config_two <= host_req.wdata;
      end
   end

   // 16-bit relocation register, relocation writes keep it even so A0 splits the pair
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         port_base <= BASE_RESET;
      end else if (clock_enable && !straps_taken && settle == 2'd2) begin
         port_base <= strap_sync2[2] ? mb_base(strap_sync2[3]) : PNP_INDEX_ADDR;
      end else if (do_wr && data_hit) begin
         case (index)
            IDX_CONFIG_TWO: begin
               port_base <= host_req.wdata[BASE_HI_BIT] ?
                            mb_base(host_req.wdata[BASE_LO_BIT]) : PNP_INDEX_ADDR;
            end
            IDX_RELOC_LO: port_base[7:0] <= {host_req.wdata[7:1], 1'b0};
            IDX_RELOC_HI: port_base[15:8] <= host_req.wdata;
            default: port_base <= port_base;
         endcase
      end
   end

   // data port reads the selected register
   always_comb begin
      case (index)
         IDX_CONFIG_ONE: data_rd = chip_config_one;
         IDX_CONFIG_TWO: data_rd = chip_config_two;
         IDX_RELOC_LO: data_rd = port_base[7:0];
         IDX_RELOC_HI: data_rd = port_base[15:8];
         default: data_rd = 8'h00;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         host_rdata <= 8'h00;
         host_ack <= 1'b0;
      end else if (clock_enable) begin
         host_ack <= (do_wr || do_rd) && (index_hit || data_hit);
         if (do_rd && index_hit) begin
            host_rdata <= index;
         end else if (do_rd && data_hit) begin
            host_rdata <= data_rd;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // shared-pin multiplexer; pads stay undriven until straps are in

   assign xbuf_en = chip_config_one[XBUF_EN_BIT];
   assign port2_sel = chip_config_one[PORT2_SEL_BIT];

   always_comb begin
      next_xb_out = 10'h000;
      next_xb_oe_n = XB_PADS_OFF;
      if (xbuf_en) begin
         // buffer data lines on pads 2-9
         next_xb_out[9:2] = xbuf_data_out;
         next_xb_oe_n[9:2] = {8{~xbuf_data_drive}};
      end else begin
         // chip selects, port-2 gpio, infrared selects
         next_xb_out[2] = chip_sel_1;
         next_xb_out[3] = chip_sel_2;
         next_xb_out[7:4] = gpio2_out;
         next_xb_out[8] = infrared_sel_2;
         next_xb_out[9] = infrared_sel_1;
         next_xb_oe_n[3:2] = 2'b00;
         next_xb_oe_n[7:4] = ~gpio2_drive;
         next_xb_oe_n[9:8] = 2'b00;
      end
      if (!straps_taken) begin
         next_xb_oe_n = XB_PADS_OFF;
      end
   end

   always_comb begin
      if (port2_sel) begin
         // serial port outputs on pads 3 and 5
         next_p3_out = {port2_serial_out, 1'b0, port2_request_to_send, 3'b000};
         next_p3_oe_n = P3_UART_OE_N;
      end else begin
         next_p3_out = gpio3_out;
         next_p3_oe_n = ~gpio3_drive;
      end
      if (!straps_taken) begin
         next_p3_oe_n = P3_PADS_OFF;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         xb_pad_out <= 10'h000;
         xb_pad_oe_n <= XB_PADS_OFF;
         p3_pad_out <= 6'h00;
         p3_pad_oe_n <= P3_PADS_OFF;
      end else if (clock_enable) begin
         xb_pad_out <= next_xb_out;
         xb_pad_oe_n <= next_xb_oe_n;
         p3_pad_out <= next_p3_out;
         p3_pad_oe_n <= next_p3_oe_n;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         xb_in <= '1;
         p3_in <= '1;
      end else if (clock_enable) begin
         xb_in.xbuf_chip_select <= xbuf_en ? xb_sync2[0] : 1'b1;
         xb_in.xbuf_read_cmd <= xbuf_en ? xb_sync2[1] : 1'b1;
         xb_in.xbuf_data_lines <= xbuf_en ? xb_sync2[9:2] : 8'hff;
         xb_in.ring_in <= xbuf_en ? 1'b1 : xb_sync2[0];
         xb_in.ident_input_3 <= xbuf_en ? 1'b1 : xb_sync2[1];
         xb_in.gpio2_in <= xbuf_en ? 4'hf : xb_sync2[7:4];
         p3_in.port2_clear_to_send <= port2_sel ? p3_sync2[0] : 1'b1;
         p3_in.port2_carrier_detect <= port2_sel ? p3_sync2[1] : 1'b1;
         p3_in.port2_set_ready <= port2_sel ? p3_sync2[2] : 1'b1;
         p3_in.port2_serial_in <= port2_sel ? p3_sync2[4] : 1'b1;
         p3_in.gpio3_in <= port2_sel ? 6'h3f : p3_sync2;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/cspm_mux_chk.sv
// checker: strap capture, port decode and pin multiplexing properties
`default_nettype none
module cspm_mux_chk (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire cspm_pkg::cspm_host_req_type host_req,
   input wire logic host_ack,
   input wire cspm_pkg::cspm_state_type config_state,
   input wire logic [7:0] chip_config_one,
   input wire logic [15:0] port_base,
   input wire logic [4:0] strap_values,
   input wire logic [9:0] xb_pad_oe_n,
   input wire logic [5:0] p3_pad_oe_n,
   input wire logic xbuf_data_drive,
   input wire cspm_pkg::cspm_xb_in_type xb_in,
   input wire cspm_pkg::cspm_p3_in_type p3_in
);
   import cspm_pkg::*;
   logic [1:0] edges;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////
   // counts enabled edges since reset; capture lands on the third
   always_ff @(posedge clock or posedge reset) begin
      if (reset) edges <= 2'h0;
      else if (clock_enable && edges != 2'h3) edges <= edges + 2'h1;
   end
   a_pads_idle: assert property (edges != 2'h3 |->
      xb_pad_oe_n == XB_PADS_OFF && p3_pad_oe_n == P3_PADS_OFF) else $error("pad driven early");
   a_wake_mode: assert property (edges == 2'h2 && clock_enable |=>
      config_state == (strap_values[2] ? CONFIG_STATE : WAIT_FOR_KEY)) else $error("wake state");
   a_port_table: assert property (edges == 2'h2 && clock_enable |=> port_base ==
      (!strap_values[2] ? PNP_INDEX_ADDR : strap_values[3] ? MB_BASE_LO1 : MB_BASE_LO0))
      else $error("port base after capture");
   a_buf_strap: assert property (edges == 2'h2 && clock_enable |=>
      chip_config_one[4] == strap_values[0]) else $error("buffer enable strap");
   a_straps_frozen: assert property (edges == 2'h3 |=> $stable(strap_values))
      else $error("strap values moved");
   a_key_no_ack: assert property (config_state == WAIT_FOR_KEY |=> !host_ack)
      else $error("ack in wait-for-key");
   a_ack_cause: assert property (host_ack |-> $past(host_req.rd || host_req.wr))
      else $error("ack without request");
   a_xb_high: assert property (!chip_config_one[4] [*5] |-> xb_in.xbuf_chip_select &&
      xb_in.xbuf_read_cmd && (&xb_in.xbuf_data_lines)) else $error("buffer inputs not high");
   a_alt_high: assert property (chip_config_one[4] [*5] |-> xb_in.ring_in &&
      xb_in.ident_input_3 && (&xb_in.gpio2_in)) else $error("alternate inputs not high");
   a_uart_high: assert property (!chip_config_one[3] [*5] |->
      p3_in.port2_clear_to_send && p3_in.port2_carrier_detect && p3_in.port2_set_ready &&
      p3_in.port2_serial_in) else $error("port-2 inputs not high");
   a_uart_pads: assert property (chip_config_one[3] [*2] |->
      p3_pad_oe_n == P3_UART_OE_N) else $error("port-2 pad drive");
   a_buf_drive: assert property (chip_config_one[4] [*3] |->
      xb_pad_oe_n[9:2] == {8{!$past(xbuf_data_drive)}}) else $error("buffer data drive");
   c_ack: cover property (host_ack);
   c_config: cover property (config_state == CONFIG_STATE ##1 chip_config_one[3]);
   c_alt: cover property (chip_config_one[4] ##1 !chip_config_one[4]);
endmodule
bind cspm_mux cspm_mux_chk cspm_mux_chk_inst (.clock(clock), .reset(reset),
   .clock_enable(clock_enable), .host_req(host_req), .host_ack(host_ack),
   .config_state(config_state), .chip_config_one(chip_config_one), .port_base(port_base),
   .strap_values(strap_values), .xb_pad_oe_n(xb_pad_oe_n), .p3_pad_oe_n(p3_pad_oe_n),
   .xbuf_data_drive(xbuf_data_drive), .xb_in(xb_in), .p3_in(p3_in));
`default_nettype wire

// >>> testbench/cspm_host_model.sv
// host model: single-cycle index and data port cycles
`default_nettype none
module cspm_host_model (
   input wire logic clock,
   output cspm_pkg::cspm_host_req_type host_req
);
   import cspm_pkg::*;
   initial host_req = '0;
   task automatic cycle(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      host_req <= {a, !wr, wr, d};
      @(negedge clock);
      // released bus shows inverted address and data with rd and wr low, never the old cycle
      host_req <= {~a, 2'h0, ~d};
   endtask
endmodule
`default_nettype wire

// >>> testbench/test_config_strap_pin_mux.sv
// testbench: strap capture, port decode and pin multiplexing
`default_nettype none
`define CHECK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_config_strap_pin_mux;
   timeunit 1ns;
   timeprecision 1ps;
   import cspm_pkg::*;
   logic clock = 1'h0, reset = 1'h1, clock_enable = 1'h1, pnp_key_seen = 1'h0;
   cspm_strap_type strap_pins = '0;
   cspm_host_req_type host_req;
   cspm_state_type config_state;
   cspm_xb_in_type xb_in;
   cspm_p3_in_type p3_in;
   logic [7:0] host_rdata, chip_config_one, chip_config_two, xbuf_data_out = '0;
   logic [15:0] port_base;
   logic [4:0] strap_values;
   logic [9:0] xb_pad_in = '0, xb_pad_out, xb_pad_oe_n;
   logic [5:0] p3_pad_in = '0, p3_pad_out, p3_pad_oe_n, gpio3_out = '0, gpio3_drive = '0;
   logic [3:0] gpio2_out = '0, gpio2_drive = '0;
   logic host_ack, xbuf_data_drive = 1'h0, chip_sel_1 = 1'h0, chip_sel_2 = 1'h0;
   logic infrared_sel_1 = 1'h0, infrared_sel_2 = 1'h0;
   logic port2_request_to_send = 1'h0, port2_serial_out = 1'h0;
   logic [8:0] note;
   logic [8:0] expect_q[$];
   int n_mismatch = 0, samples_checked = 0, cycles = 0;
   always #2 clock = ~clock;
   cspm_host_model cspm_host_model_inst (.clock(clock), .host_req(host_req));
   cspm_mux cspm_mux_inst (.clock(clock), .reset(reset), .clock_enable(clock_enable),
      .strap_pins(strap_pins), .pnp_key_seen(pnp_key_seen), .host_req(host_req),
      .host_rdata(host_rdata), .host_ack(host_ack), .config_state(config_state),
      .chip_config_one(chip_config_one), .chip_config_two(chip_config_two),
      .port_base(port_base), .strap_values(strap_values), .xb_pad_in(xb_pad_in),
      .xb_pad_out(xb_pad_out), .xb_pad_oe_n(xb_pad_oe_n), .p3_pad_in(p3_pad_in),
      .p3_pad_out(p3_pad_out), .p3_pad_oe_n(p3_pad_oe_n), .xbuf_data_out(xbuf_data_out),
      .xbuf_data_drive(xbuf_data_drive), .chip_sel_1(chip_sel_1), .chip_sel_2(chip_sel_2),
      .gpio2_out(gpio2_out), .gpio2_drive(gpio2_drive), .infrared_sel_1(infrared_sel_1),
      .infrared_sel_2(infrared_sel_2), .port2_request_to_send(port2_request_to_send),
      .port2_serial_out(port2_serial_out), .gpio3_out(gpio3_out),
      .gpio3_drive(gpio3_drive), .xb_in(xb_in), .p3_in(p3_in));
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // watcher: every ack consumes the oldest note; a stray ack fails
   always @(negedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         complete_run();
      end
      if (host_ack === 1'h1 && expect_q.size() == 0) `CHECK(host_ack, 1'h0)
      else if (host_ack === 1'h1) begin
         note = expect_q.pop_front();
         if (note[8]) `CHECK(host_rdata, note[7:0])
      end
   end
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      input logic ok, input logic [7:0] e);
      if (ok) expect_q.push_back({!wr, e});
      cspm_host_model_inst.cycle(wr, a, d);
      repeat (2) @(negedge clock);
   endtask
   task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
      acc(1'h1, port_base, idx, 1'h1, 8'h00);
      acc(1'h1, port_base | 16'h0001, v, 1'h1, 8'h00);
   endtask
   task automatic do_reset(input logic [4:0] s);
      @(negedge clock);
      reset = 1'h1;
      strap_pins = s[3:0];
      xb_pad_in[8] = s[4];
      repeat (10) @(negedge clock);
      reset = 1'h0;
      repeat (6) @(negedge clock);
      // straps move after capture; captured values must not follow
      strap_pins = ~strap_pins;
      xb_pad_in = 10'($urandom);
      repeat (4) @(negedge clock);
   endtask
   task automatic pin_check(input logic xb, input logic u);
      logic [7:0] off;
      off = {8{!xbuf_data_drive}};
      if (xb) begin
         `CHECK(xb_in, {xb_pad_in[0], xb_pad_in[1], xb_pad_in[9:2], 6'h3f})
         `CHECK(xb_pad_oe_n, {off, 2'h3})
         `CHECK(xb_pad_out[9:2] | off, xbuf_data_out | off)
      end else begin
         `CHECK(xb_in, {10'h3ff, xb_pad_in[0], xb_pad_in[1], xb_pad_in[7:4]})
         `CHECK(xb_pad_oe_n, {2'h0, ~gpio2_drive, 2'h0, 2'h3})
         `CHECK(xb_pad_out[9:8], {infrared_sel_1, infrared_sel_2})
         `CHECK(xb_pad_out[7:2], {gpio2_out, chip_sel_2, chip_sel_1})
      end
      if (u) begin
         `CHECK(p3_in, {p3_pad_in[0], p3_pad_in[1], p3_pad_in[2], p3_pad_in[4], 6'h3f})
         `CHECK(p3_pad_out[5:3] & 3'h5, {port2_serial_out, 1'h0, port2_request_to_send})
      end else begin
         `CHECK(p3_in, {4'hf, p3_pad_in})
         `CHECK(p3_pad_oe_n, ~gpio3_drive)
         `CHECK(p3_pad_out & gpio3_drive, gpio3_out & gpio3_drive)
      end
   endtask
   initial begin
      logic [4:0] s;
      logic [15:0] b;
      logic [63:0] r;
      void'($urandom(32'hb303));
      for (int i = 0; i < 4; i++) begin
         s = 5'($urandom);
         s[3:2] = {i[0], i[1]};
         // routing strap low with buffer strap high is not a legal combination
         s[4] = s[4] | s[0];
         do_reset(s);
         b = !s[2] ? PNP_INDEX_ADDR : s[3] ? MB_BASE_LO1 : MB_BASE_LO0;
         `CHECK(strap_values, s)
         `CHECK(port_base, b)
         `CHECK(config_state, s[2] ? CONFIG_STATE : WAIT_FOR_KEY)
         `CHECK(chip_config_two[1:0], {s[2], s[3]})
         if (!s[2]) begin
            acc(1'h1, b, IDX_CONFIG_ONE, 1'h0, 8'h00);
            pnp_key_seen = 1'h1;
            repeat (6) @(negedge clock);
            pnp_key_seen = 1'h0;
            `CHECK(config_state, CONFIG_STATE)
            acc(1'h1, b, IDX_CONFIG_ONE, 1'h1, 8'h00);
            acc(1'h0, b, 8'h00, 1'h0, 8'h00);
            acc(1'h1, PNP_DATA_WR_ADDR, 8'h18, 1'h1, 8'h00);
            `CHECK(chip_config_one[4:3], 2'h3)
         end else begin
            acc(1'h1, b, IDX_CONFIG_ONE, 1'h1, 8'h00);
            acc(1'h0, b, 8'h00, 1'h1, IDX_CONFIG_ONE);
            acc(1'h0, b | 16'h0001, 8'h00, 1'h1, {3'h0, s[0], 2'h0, s[4], 1'h0});
         end
         $display("strap case %0d done", i);
      end
      wreg(IDX_RELOC_HI, 8'h03);
      wreg(IDX_RELOC_LO, 8'h41);
      `CHECK(port_base, 16'h0340)
      acc(1'h0, 16'h0341, 8'h00, 1'h1, 8'h40);
      // frozen clock enable: the index write must be ignored and never acknowledged
      clock_enable = 1'h0;
      acc(1'h1, 16'h0340, IDX_CONFIG_TWO, 1'h0, 8'h00);
      clock_enable = 1'h1;
      acc(1'h0, 16'h0340, 8'h00, 1'h1, IDX_RELOC_LO);
      $display("relocation done");
      for (int m = 0; m < 4; m++) begin
         wreg(IDX_CONFIG_ONE, {3'h0, m[1], m[0], 3'h2});
         r = {$urandom, $urandom};
         {xb_pad_in, p3_pad_in, xbuf_data_out, gpio3_out, gpio3_drive} = r[35:0];
         {xbuf_data_drive, chip_sel_1, chip_sel_2, infrared_sel_1, infrared_sel_2} = r[40:36];
         {gpio2_out, gpio2_drive, port2_request_to_send, port2_serial_out} = r[50:41];
         repeat (5) @(negedge clock);
         pin_check(m[1], m[0]);
         $display("pin mode %0d done", m);
      end
      // firmware returns the ports to the standard pair
      wreg(IDX_CONFIG_TWO, 8'h02);
      `CHECK(port_base, MB_BASE_LO0)
      wreg(IDX_CONFIG_TWO, 8'h00);
      `CHECK(port_base, PNP_INDEX_ADDR)
      acc(1'h0, PNP_INDEX_ADDR, 8'h00, 1'h0, 8'h00);
      `CHECK(expect_q.size(), 0)
      $display("port move done");
      complete_run();
   end
endmodule
`default_nettype wire
